/* logic/mode_pin_pkg.sv */
// Constants shared by the mode pin decoder and its synchroniser
`default_nettype none
package mode_pin_pkg;
  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  localparam int unsigned SYNC_WIDTH    = 9;
  localparam int unsigned SYNC_MODE     = 0;
  localparam int unsigned SYNC_PIN0     = 1;
  localparam int unsigned SYNC_PIN0_FLT = 2;
  localparam int unsigned SYNC_PIN1     = 3;
  localparam int unsigned SYNC_PIN2     = 4;
  localparam int unsigned SYNC_PIN3     = 5;
  localparam int unsigned SYNC_CS_N     = 6;
  localparam int unsigned SYNC_PRESENT  = 7;
  localparam int unsigned SYNC_OVER_REF = 8;
  // Reset pattern: hardware mode, chip select idle high
  localparam logic [SYNC_WIDTH-1:0] SYNC_RST_VAL = 9'h040;
  // ----------------------------------------------------------------
  // Configuration byte fields
  // ----------------------------------------------------------------
  localparam int unsigned CFG_WIDTH      = 8;
  localparam int unsigned CFG_EQ_BYP_BIT = 5;
  localparam int unsigned CFG_PDIS_HI    = 4;
  localparam int unsigned CFG_PDIS_LO    = 3;
  localparam int unsigned CFG_SD_BIT     = 7;
  localparam logic [CFG_WIDTH-1:0] CFG_RD_RST_VAL = 8'h00;
  // ----------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------
  localparam logic MODE_SOFTWARE = 1'h1;
  localparam logic SD_N_RST_VAL  = 1'h1;
  localparam logic CS_N_IDLE     = 1'h1;
endpackage
`default_nettype wire

/* logic/pin_sync_if.sv */
// Synchronised pin levels passed from synchroniser to decoder
`default_nettype none
interface pin_sync_if;
  logic mode;
  logic pin0;
  logic pin0_float;
  logic pin1;
  logic pin2;
  logic pin3;
  logic cs_n;
  logic present;
  logic over_ref;
  modport src (output mode, pin0, pin0_float, pin1, pin2, pin3, cs_n, present, over_ref);
  modport dst (input  mode, pin0, pin0_float, pin1, pin2, pin3, cs_n, present, over_ref);
endinterface
`default_nettype wire

/* logic/pin_level_sync.sv */
// Two-flop synchroniser bank for all pin and analog status levels
`default_nettype none
module pin_level_sync
  import mode_pin_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic mode_select_i,
  input  wire logic pin0_i,
  input  wire logic pin0_float_i,
  input  wire logic pin1_i,
  input  wire logic pin2_i,
  input  wire logic pin3_i,
  input  wire logic chip_select_n_i,
  input  wire logic signal_present_i,
  input  wire logic over_length_ref_i,
  pin_sync_if.src   sync_o
);
  logic [SYNC_WIDTH-1:0] raw;
  logic [SYNC_WIDTH-1:0] meta_r;
  logic [SYNC_WIDTH-1:0] stable_r;

  assign raw = {over_length_ref_i, signal_present_i, chip_select_n_i, pin3_i, pin2_i,
                pin1_i, pin0_float_i, pin0_i, mode_select_i};

  // ----------------------------------------------------------------
  // Two stages; first stage read only by second
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      meta_r   <= SYNC_RST_VAL;
      stable_r <= SYNC_RST_VAL;
    end else begin
      meta_r   <= raw;
      stable_r <= meta_r;
    end
  end

  assign sync_o.mode       = stable_r[SYNC_MODE];
  assign sync_o.pin0       = stable_r[SYNC_PIN0];
  assign sync_o.pin0_float = stable_r[SYNC_PIN0_FLT];
  assign sync_o.pin1       = stable_r[SYNC_PIN1];
  assign sync_o.pin2       = stable_r[SYNC_PIN2];
  assign sync_o.pin3       = stable_r[SYNC_PIN3];
  assign sync_o.cs_n       = stable_r[SYNC_CS_N];
  assign sync_o.present    = stable_r[SYNC_PRESENT];
  assign sync_o.over_ref   = stable_r[SYNC_OVER_REF];
endmodule
`default_nettype wire

/* logic/mode_pin_control_decoder.sv */
// Multifunction control pin decoder for hardware and software mode
//
// Operation
// - Mode select high gives software mode with the serial port, low gives hardware mode.
// - In hardware mode pin zero high bypasses equalizer and jitter cleaner, float bypasses the cleaner only, low is normal.
// - In software mode pin zero drives signal detect complement, 1 on no input or over-length cable.
// - In hardware mode pin one high powers down on no input, low keeps the equalizer active.
// - Automatic sleep wins over mute and bypass.
// - In software mode pin one drives the serial data output.
// - In hardware mode pin two high mutes the outputs, low is normal.
// - Mute wins over bypass.
// - In software mode pin two is the serial clock input.
// - In hardware mode pin three drives active-low signal detect.
// - In software mode pin three is the serial data input.
// - In software mode configuration bit 5 set bypasses the equalizer.
// - Configuration bits 4 to 3 in software mode, or pin one low in hardware mode, disable signal-detect power-off.
// - Signal detect status also reads back in configuration bit 7.
`default_nettype none
module mode_pin_control_decoder
  import mode_pin_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rstn_i,
  input  wire logic                 mode_select_i,
  input  wire logic                 multifunction_pin_zero_i,
  input  wire logic                 multifunction_pin_zero_float_i,
  output logic                      multifunction_pin_zero_o,
  output logic                      multifunction_pin_zero_oe_o,
  input  wire logic                 multifunction_pin_one_i,
  output logic                      multifunction_pin_one_o,
  output logic                      multifunction_pin_one_oe_o,
  input  wire logic                 multifunction_pin_two_i,
  input  wire logic                 multifunction_pin_three_i,
  output logic                      multifunction_pin_three_o,
  output logic                      multifunction_pin_three_oe_o,
  input  wire logic                 chip_select_n_i,
  input  wire logic                 signal_present_i,
  input  wire logic                 over_length_ref_i,
  input  wire logic [CFG_WIDTH-1:0] general_config_reg_i,
  input  wire logic                 serial_out_data_i,
  output logic [CFG_WIDTH-1:0]      general_config_rd_o,
  output logic                      software_mode_o,
  output logic                      serial_clock_o,
  output logic                      serial_data_in_o,
  output logic                      serial_chip_select_n_o,
  output logic                      eq_bypass_o,
  output logic                      cleaner_bypass_o,
  output logic                      mute_o,
  output logic                      power_down_o,
  output logic                      signal_detect_n_flag_o
);
  pin_sync_if sy ();

  logic sw_mode;
  logic sd_n;
  logic poweroff_en;
  logic sleep_req;
  logic mute_req;
  logic eq_byp_req;
  logic jc_byp_req;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  pin_level_sync u_sync (
    .clk_i             (clk_i),
    .rstn_i            (rstn_i),
    .mode_select_i     (mode_select_i),
    .pin0_i            (multifunction_pin_zero_i),
    .pin0_float_i      (multifunction_pin_zero_float_i),
    .pin1_i            (multifunction_pin_one_i),
    .pin2_i            (multifunction_pin_two_i),
    .pin3_i            (multifunction_pin_three_i),
    .chip_select_n_i   (chip_select_n_i),
    .signal_present_i  (signal_present_i),
    .over_length_ref_i (over_length_ref_i),
    .sync_o            (sy.src)
  );

  // ----------------------------------------------------------------
  // Request decode and priority
  // ----------------------------------------------------------------
  always_comb begin
    sw_mode     = (sy.mode == MODE_SOFTWARE);
    sd_n        = !sy.present || sy.over_ref;
    poweroff_en = sw_mode ? !(|general_config_reg_i[CFG_PDIS_HI:CFG_PDIS_LO]) : sy.pin1;
    sleep_req   = poweroff_en && !sy.present;
    mute_req    = !sw_mode && sy.pin2 && !sleep_req;
    eq_byp_req  = 1'h0;
    jc_byp_req  = 1'h0;
    if (!sleep_req && !mute_req) begin
      if (sw_mode) begin
        eq_byp_req = general_config_reg_i[CFG_EQ_BYP_BIT];
      end else if (sy.pin0_float) begin
        jc_byp_req = 1'h1;
      end else if (sy.pin0) begin
        eq_byp_req = 1'h1;
        jc_byp_req = 1'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Core controls
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      software_mode_o  <= 1'h0;
      power_down_o     <= 1'h0;
      mute_o           <= 1'h0;
      eq_bypass_o      <= 1'h0;
      cleaner_bypass_o <= 1'h0;
    end else begin
      software_mode_o  <= sw_mode;
      power_down_o     <= sleep_req;
      mute_o           <= mute_req;
      eq_bypass_o      <= eq_byp_req;
      cleaner_bypass_o <= jc_byp_req;
    end
  end

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      signal_detect_n_flag_o <= SD_N_RST_VAL;
      general_config_rd_o    <= CFG_RD_RST_VAL;
    end else begin
      signal_detect_n_flag_o <= sd_n;
      general_config_rd_o    <= {!sd_n, general_config_reg_i[CFG_SD_BIT-1:0]};
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      multifunction_pin_zero_o     <= SD_N_RST_VAL;
      multifunction_pin_zero_oe_o  <= 1'h0;
      multifunction_pin_one_o      <= 1'h0;
      multifunction_pin_one_oe_o   <= 1'h0;
      multifunction_pin_three_o    <= SD_N_RST_VAL;
      multifunction_pin_three_oe_o <= 1'h0;
    end else begin
      multifunction_pin_zero_o     <= sd_n;
      multifunction_pin_zero_oe_o  <= sw_mode;
      multifunction_pin_one_o      <= serial_out_data_i;
      multifunction_pin_one_oe_o   <= sw_mode;
      multifunction_pin_three_o    <= sd_n;
      multifunction_pin_three_oe_o <= !sw_mode;
    end
  end

  // ----------------------------------------------------------------
  // Serial port forwarding
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      serial_clock_o         <= 1'h0;
      serial_data_in_o       <= 1'h0;
      serial_chip_select_n_o <= CS_N_IDLE;
    end else begin
      serial_clock_o         <= sw_mode && sy.pin2;
      serial_data_in_o       <= sw_mode && sy.pin3;
      serial_chip_select_n_o <= sw_mode ? sy.cs_n : CS_N_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  mode_follow_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ##1 software_mode_o == $past(sy.mode)) else $error("mode not followed");
  hw_bypass_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!sy.mode && !sy.pin1 && !sy.pin2 && sy.pin0 && !sy.pin0_float)
    |=> eq_bypass_o && cleaner_bypass_o) else $error("hw full bypass missing");
  hw_float_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!sy.mode && !sy.pin1 && !sy.pin2 && sy.pin0_float)
    |=> !eq_bypass_o && cleaner_bypass_o) else $error("float bypass wrong");
  sw_detect_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sy.mode |=> multifunction_pin_zero_oe_o && !multifunction_pin_three_oe_o
    && (multifunction_pin_zero_o == $past(!sy.present || sy.over_ref)))
    else $error("sw detect pin wrong");
  auto_sleep_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!sy.mode && sy.pin1 && !sy.present) |=> power_down_o)
    else $error("sleep not entered");
  always_on_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!sy.mode && !sy.pin1) |=> !power_down_o) else $error("sleep with pin low");
  sleep_prio_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    power_down_o |-> !mute_o && !eq_bypass_o && !cleaner_bypass_o)
    else $error("sleep lost priority");
  data_out_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sy.mode |=> multifunction_pin_one_oe_o
    && (multifunction_pin_one_o == $past(serial_out_data_i)))
    else $error("serial out not driven");
  hw_mute_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!sy.mode && sy.pin2 && !(sy.pin1 && !sy.present)) |=> mute_o)
    else $error("mute missing");
  mute_prio_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    mute_o |-> !eq_bypass_o && !cleaner_bypass_o) else $error("bypass beat mute");
  sclk_fwd_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sy.mode |=> serial_clock_o == $past(sy.pin2)) else $error("sclk not forwarded");
  hw_detect_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (rstn_i && !sy.mode) |=> multifunction_pin_three_oe_o && !multifunction_pin_one_oe_o
    && (multifunction_pin_three_o == $past(!sy.present || sy.over_ref)))
    else $error("hw detect pin wrong");
  data_in_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sy.mode |=> serial_data_in_o == $past(sy.pin3)) else $error("data in lost");
  cfg_bypass_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (sy.mode && !power_down_o && !sleep_req)
    |=> eq_bypass_o == $past(general_config_reg_i[CFG_EQ_BYP_BIT]))
    else $error("cfg bypass wrong");
  status_bit_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ##1 general_config_rd_o[CFG_SD_BIT] == !signal_detect_n_flag_o)
    else $error("status bit mismatch");
  pin_settle_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!mode_select_i && !multifunction_pin_one_i && multifunction_pin_two_i)[*4]
    |-> mute_o) else $error("mute not settled");
endmodule
`default_nettype wire

/* bench/host_strap_model.sv */
// Board strap and host controller model for the multifunction pins
`default_nettype none
module host_strap_model (
  input  wire logic       sw_i,
  input  wire logic       lvl0_i,
  input  wire logic       flt0_i,
  input  wire logic       lvl1_i,
  input  wire logic       lvl2_i,
  input  wire logic       sdi_i,
  input  wire logic       cs_n_i,
  input  wire logic [2:0] dev_i,
  input  wire logic [2:0] oe_i,
  output logic            mode_o,
  output logic            pin0_o,
  output logic            pin0_float_o,
  output logic            pin1_o,
  output logic            pin2_o,
  output logic            pin3_o,
  output logic            cs_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Wire levels
  // ----------------------------------------------------------------
  assign mode_o       = sw_i;
  assign pin0_o       = oe_i[0] ? dev_i[0] : (flt0_i ? ~dev_i[0] : lvl0_i);
  assign pin0_float_o = !oe_i[0] && flt0_i;
  assign pin1_o       = oe_i[1] ? dev_i[1] : (sw_i ? 1'h1 : lvl1_i);
  assign pin2_o       = lvl2_i;
  assign pin3_o       = oe_i[2] ? dev_i[2] : (sw_i ? sdi_i : 1'h0);
  assign cs_n_o       = sw_i ? cs_n_i : 1'h0;
endmodule
`default_nettype wire

/* bench/mode_pin_control_decoder_bench.sv */
// Self-checking bench for the mode pin control decoder
`default_nettype none
module mode_pin_control_decoder_bench;
  import mode_pin_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic       clk_i, rstn_i, sw, p0, p0f, p1, p2, sdi, cs_n, present, over_ref, sout;
  logic [7:0] cfg, rd;
  logic       mode_w, p0_w, p0f_w, p1_w, p2_w, p3_w, cs_w;
  logic [2:0] dev, oe;
  logic       sw_mode, sclk, sdin, scs_n, eq, cl, mute, pd, sd_n;
  int         mismatches, checks;

  host_strap_model i_host (.sw_i(sw), .lvl0_i(p0), .flt0_i(p0f), .lvl1_i(p1), .lvl2_i(p2),
    .sdi_i(sdi), .cs_n_i(cs_n), .dev_i(dev), .oe_i(oe), .mode_o(mode_w), .pin0_o(p0_w),
    .pin0_float_o(p0f_w), .pin1_o(p1_w), .pin2_o(p2_w), .pin3_o(p3_w), .cs_n_o(cs_w));

  mode_pin_control_decoder i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .mode_select_i(mode_w),
    .multifunction_pin_zero_i(p0_w), .multifunction_pin_zero_float_i(p0f_w),
    .multifunction_pin_zero_o(dev[0]), .multifunction_pin_zero_oe_o(oe[0]),
    .multifunction_pin_one_i(p1_w), .multifunction_pin_one_o(dev[1]),
    .multifunction_pin_one_oe_o(oe[1]), .multifunction_pin_two_i(p2_w),
    .multifunction_pin_three_i(p3_w), .multifunction_pin_three_o(dev[2]),
    .multifunction_pin_three_oe_o(oe[2]), .chip_select_n_i(cs_w),
    .signal_present_i(present), .over_length_ref_i(over_ref), .general_config_reg_i(cfg),
    .serial_out_data_i(sout), .general_config_rd_o(rd), .software_mode_o(sw_mode),
    .serial_clock_o(sclk), .serial_data_in_o(sdin), .serial_chip_select_n_o(scs_n),
    .eq_bypass_o(eq), .cleaner_bypass_o(cl), .mute_o(mute), .power_down_o(pd),
    .signal_detect_n_flag_o(sd_n));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check_byte({7'h00, got}, {7'h00, exp});
  endtask

  task automatic settle;
    repeat (5) @(posedge clk_i);
    #1;
  endtask

  // Pins are {level0, float0, pin1, pin2, present}; result {eq, cleaner, mute, sleep}
  task automatic hw(input logic [4:0] pins, input logic [3:0] exp);
    @(posedge clk_i);
    {p0, p0f, p1, p2, present} <= pins;
    settle;
    check_byte({4'h0, eq, cl, mute, pd}, {4'h0, exp});
  endtask
  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    repeat (3000) @(posedge clk_i);
    mismatches++;
    give_verdict;
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {rstn_i, sw, p0, p0f, p1, p2, sdi, cs_n, present, over_ref, sout} = 11'h000;
    cfg = 8'h00;
    mismatches = 0;
    checks = 0;
    repeat (5) @(posedge clk_i);
    #1;
    check_bit(oe[0], 1'h0);
    check_bit(sd_n, SD_N_RST_VAL);
    check_byte(rd, CFG_RD_RST_VAL);
    check_bit(scs_n, CS_N_IDLE);
    @(posedge clk_i);
    rstn_i <= 1'b1;
    hw(5'h01, 4'h0);
    hw(5'h11, 4'hC);
    hw(5'h09, 4'h4);
    hw(5'h03, 4'h2);
    hw(5'h13, 4'h2);
    hw(5'h16, 4'h1);
    hw(5'h04, 4'h1);
    hw(5'h00, 4'h0);
    hw(5'h05, 4'h0);
    check_bit(sw_mode, 1'h0);
    check_bit(oe[0], 1'h0);
    check_bit(oe[2], 1'h1);
    check_bit(dev[2], 1'h0);
    check_bit(sd_n, 1'h0);
    check_bit(scs_n, 1'h1);
    @(posedge clk_i);
    over_ref <= 1'b1;
    settle;
    check_bit(dev[2], 1'h1);
    check_bit(sd_n, 1'h1);
    @(posedge clk_i);
    {sw, over_ref, present, p2} <= 4'h8;
    cfg <= 8'h20;
    settle;
    check_bit(sw_mode, MODE_SOFTWARE);
    check_byte({5'h00, oe}, 8'h03);
    check_bit(dev[0], 1'h1);
    check_bit(eq, 1'h0);
    check_bit(pd, 1'h1);
    check_byte(rd, 8'h20);
    for (int i = 1; i < 4; i++) begin
      @(posedge clk_i);
      cfg <= 8'h20 | 8'(i << 3);
      settle;
      check_bit(pd, 1'h0);
      check_bit(eq, 1'h1);
    end
    @(posedge clk_i);
    {present, p2, sdi, cs_n, sout} <= 5'h1F;
    cfg <= 8'h00;
    settle;
    check_bit(dev[0], 1'h0);
    check_byte(rd, 8'h80);
    check_bit(sclk, 1'h1);
    check_bit(sdin, 1'h1);
    check_bit(scs_n, 1'h1);
    check_bit(dev[1], 1'h1);
    check_bit(mute, 1'h0);
    check_bit(eq, 1'h0);
    @(posedge clk_i);
    {cs_n, sout} <= 2'h0;
    @(posedge clk_i);
    #1;
    check_bit(dev[1], 1'h0);
    settle;
    check_bit(scs_n, 1'h0);
    give_verdict;
  end
endmodule
`default_nettype wire
